// >>> hw/tel_event_latches.sv
// T1 event flag word and counter overflow latches behind an AHB-Lite slave
//
// Contract
// - hdlc controller 0,1,2 interrupts set event bits 7,6,5
// - loop-up or loop-down code held 48 ms sets event bit 4
// - rising edge of the one-second status sets event bit 3
// - rising edge of the five-second status sets event bit 2
// - a valid message differing from the last accepted one sets event bit 1
// - a new message counts as valid once seen in 8 of last 10 positions
// - signalling change, debounced when enabled, sets event bit 0
// - reading the event word returns it, then clears the bits that were set
// - fbit, crc6, out-of-frame, realign overflows latch into bits 7..4
// - code violation, prbs, prbs multiframe, sync loss overflows latch bits 3..0
// - overflow latches hold until read and clear at the edge that ends the read's address phase; the code also clears bits written with ones
// - wrap of the prbs multiframe counter sets overflow bit 1
// - a counter overflows when it goes from all ones to zero
// - an event mask bit of one lets its source set its flag; overflow mask bits gate only irq
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module tel_event_latches
  import tel_pkg::*;
#(
  parameter int LoopHoldCycles = LOOP_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tel_line_status_t lineStatus,
  input wire tel_link_data_t linkData,
  input wire logic [NUM_COUNTERS-1:0][7:0] perfCount,
  output logic irq
);
  // ----------------------------------------------------------------
  // bus slave: zero wait states, reads act at the address phase
  // ----------------------------------------------------------------
  logic addrPhase;
  logic [7:0] busIdx;
  logic rdEvent;
  logic rdOvf;
  logic wrPend_r;
  logic [7:0] wrIdx_r;
  logic [7:0] eventFlags_r;
  logic [7:0] eventFlags_nxt;
  logic [7:0] ovfLatch_r;
  logic [7:0] ovfLatch_nxt;
  logic [7:0] eventMask_r;
  logic [7:0] ovfMask_r;
  logic [7:0] control_r;
  logic [7:0] readByte;

  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign busIdx = haddr[IDX_MSB:IDX_LSB];
  assign rdEvent = addrPhase & ~hwrite & (busIdx == IDX_EVENT_FLAGS);
  assign rdOvf = addrPhase & ~hwrite & (busIdx == IDX_OVF_LATCHES);

  always_comb begin
    case (busIdx)
      IDX_EVENT_FLAGS: readByte = eventFlags_r;
      IDX_OVF_LATCHES: readByte = ovfLatch_r;
      IDX_EVENT_MASK: readByte = eventMask_r;
      IDX_OVF_MASK: readByte = ovfMask_r;
      IDX_CONTROL: readByte = control_r;
      default: readByte = RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrPend_r <= 1'b0;
      wrIdx_r <= RST_BYTE;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wrPend_r <= addrPhase & hwrite;
      wrIdx_r <= busIdx;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase && !hwrite) begin
        hrdata <= {24'h00_0000, readByte};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eventMask_r <= RST_BYTE;
      ovfMask_r <= RST_BYTE;
      control_r <= RST_BYTE;
    end else if (wrPend_r) begin
      if (wrIdx_r == IDX_EVENT_MASK) eventMask_r <= hwdata[7:0];
      if (wrIdx_r == IDX_OVF_MASK) ovfMask_r <= hwdata[7:0];
      if (wrIdx_r == IDX_CONTROL) control_r <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // loop code persistence timer
  // ----------------------------------------------------------------
  localparam int LoopW = $clog2(LoopHoldCycles + 1);
  localparam logic [LoopW-1:0] LoopLast = LoopW'(LoopHoldCycles - 1);
  logic [LoopW-1:0] loopCnt_r;
  logic loopSeen;
  logic loopHit;

  assign loopSeen = lineStatus.loopUpSeen | lineStatus.loopDownSeen;
  assign loopHit = loopSeen & (loopCnt_r == LoopLast);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      loopCnt_r <= '0;
    end else if (!loopSeen) begin
      loopCnt_r <= '0;
    end else if (loopCnt_r != LoopW'(LoopHoldCycles)) begin
      loopCnt_r <= loopCnt_r + LoopW'(1);
    end
  end

  // ----------------------------------------------------------------
  // status edges
  // ----------------------------------------------------------------
  logic oneSecPrev_r;
  logic fiveSecPrev_r;
  logic oneSecRise;
  logic fiveSecRise;

  assign oneSecRise = lineStatus.oneSecStatus & ~oneSecPrev_r;
  assign fiveSecRise = lineStatus.fiveSecStatus & ~fiveSecPrev_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      oneSecPrev_r <= 1'b0;
      fiveSecPrev_r <= 1'b0;
    end else begin
      oneSecPrev_r <= lineStatus.oneSecStatus;
      fiveSecPrev_r <= lineStatus.fiveSecStatus;
    end
  end

  // ----------------------------------------------------------------
  // bit-oriented message vote over the last message positions
  // ----------------------------------------------------------------
  logic [BOM_CODE_W-1:0] bomHist_r [BOM_WINDOW-1];
  logic [BOM_WINDOW-2:0] bomHistOk_r;
  logic [BOM_WINDOW-2:0] bomMatch;
  logic [BOM_CODE_W-1:0] bomCode;
  logic [BOM_CODE_W-1:0] bomAccepted_r;
  logic bomHave_r;
  logic bomOk;
  logic bomValid;
  logic bomNew;

  assign bomCode = linkData.bomWord[BOM_CODE_W:1];
  assign bomOk = (linkData.bomWord[BOM_WIDTH-1:BOM_CODE_W+1] == BOM_FLAG)
               & ~linkData.bomWord[0];

  for (genvar i = 0; i < BOM_WINDOW - 1; i++) begin : g_bomVote
    assign bomMatch[i] = bomHistOk_r[i] & (bomHist_r[i] == bomCode);
  end

  // the incoming word is its own tenth position, so seven stored matches suffice
  assign bomValid = bomOk & (($countones(bomMatch) + 1) >= BOM_NEEDED);
  assign bomNew = linkData.bomStrobe & bomValid
                & (~bomHave_r | (bomCode != bomAccepted_r));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bomHistOk_r <= '0;
      bomHave_r <= 1'b0;
      bomAccepted_r <= '0;
      for (int k = 0; k < BOM_WINDOW - 1; k++) bomHist_r[k] <= '0;
    end else if (linkData.bomStrobe) begin
      bomHist_r[0] <= bomCode;
      for (int k = 1; k < BOM_WINDOW - 1; k++) bomHist_r[k] <= bomHist_r[k-1];
      bomHistOk_r <= {bomHistOk_r[BOM_WINDOW-3:0], bomOk};
      if (bomNew) begin
        bomAccepted_r <= bomCode;
        bomHave_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // signalling change of state
  // ----------------------------------------------------------------
  logic [SIG_WIDTH-1:0] sigPrev_r;
  logic [SIG_WIDTH-1:0] sigAccepted_r;
  logic sigStable;
  logic sigChange;

  // debounce asks for two equal samples in a row; costs one signalling period of delay
  assign sigStable = ~control_r[CTL_DEBOUNCE] | (linkData.sigSample == sigPrev_r);
  assign sigChange = linkData.sigStrobe & sigStable
                   & (linkData.sigSample != sigAccepted_r);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sigPrev_r <= '0;
      sigAccepted_r <= '0;
    end else if (linkData.sigStrobe) begin
      sigPrev_r <= linkData.sigSample;
      if (sigChange) sigAccepted_r <= linkData.sigSample;
    end
  end

  // ----------------------------------------------------------------
  // counter wrap detection, one per counter
  // ----------------------------------------------------------------
  logic [NUM_COUNTERS-1:0][7:0] cntPrev_r;
  logic [NUM_COUNTERS-1:0] cntWrap;

  for (genvar c = 0; c < NUM_COUNTERS; c++) begin : g_wrap
    assign cntWrap[c] = (cntPrev_r[c] == CNT_ALL_ONES)
                      & (perfCount[c] == CNT_ZERO);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cntPrev_r <= '0;
    end else begin
      cntPrev_r <= perfCount;
    end
  end

  // ----------------------------------------------------------------
  // flag words: set beats clear
  // ----------------------------------------------------------------
  logic [7:0] eventRaw;
  logic [7:0] eventClr;
  logic [7:0] ovfClr;

  always_comb begin
    eventRaw = RST_BYTE;
    eventRaw[EVT_HDLC0 -: 3] = lineStatus.hdlcIrq;
    eventRaw[EVT_LOOP] = loopHit;
    eventRaw[EVT_ONESEC] = oneSecRise;
    eventRaw[EVT_FIVESEC] = fiveSecRise;
    eventRaw[EVT_BOM] = bomNew;
    eventRaw[EVT_SIG] = sigChange;
  end

  // clear by read, or by writing ones in the data phase
  assign eventClr = (rdEvent ? eventFlags_r : RST_BYTE)
                  | ((wrPend_r && wrIdx_r == IDX_EVENT_FLAGS) ? hwdata[7:0] : RST_BYTE);
  assign ovfClr = (rdOvf ? ovfLatch_r : RST_BYTE)
                | ((wrPend_r && wrIdx_r == IDX_OVF_LATCHES) ? hwdata[7:0] : RST_BYTE);
  assign eventFlags_nxt = (eventFlags_r & ~eventClr) | (eventRaw & eventMask_r);
  assign ovfLatch_nxt = (ovfLatch_r & ~ovfClr) | cntWrap;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      eventFlags_r <= RST_BYTE;
      ovfLatch_r <= RST_BYTE;
      irq <= 1'b0;
    end else begin
      eventFlags_r <= eventFlags_nxt;
      ovfLatch_r <= ovfLatch_nxt;
      irq <= (|eventFlags_nxt) | (|(ovfLatch_nxt & ovfMask_r));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence sReadEvent;
    rdEvent ##1 1'b1;
  endsequence

  hdlc_flag_set_a: assert property (lineStatus.hdlcIrq[0] && eventMask_r[EVT_HDLC0-2]
    |=> eventFlags_r[EVT_HDLC0-2]) else $error("hdlc2 event not flagged");
  loop_hold_a: assert property (loopHit |-> ($past(loopSeen) && loopCnt_r == LoopLast)
    ##1 (!loopHit && (eventFlags_r[EVT_LOOP] || !$past(eventMask_r[EVT_LOOP]))))
    else $error("loop flag not raised once");
  one_sec_edge_a: assert property (
    $rose(lineStatus.oneSecStatus) && eventMask_r[EVT_ONESEC] |=> eventFlags_r[EVT_ONESEC])
    else $error("second edge lost");
  five_sec_edge_a: assert property (
    $rose(lineStatus.fiveSecStatus) && eventMask_r[EVT_FIVESEC] |=> eventFlags_r[EVT_FIVESEC])
    else $error("five second edge lost");
  bom_accept_a: assert property (bomNew
    |=> bomAccepted_r == $past(bomCode) && bomHave_r) else $error("message not accepted");
  sig_debounce_a: assert property (sigChange && control_r[CTL_DEBOUNCE]
    |-> linkData.sigSample == sigPrev_r) else $error("undebounced change");
  read_clear_a: assert property (sReadEvent |-> hrdata[7:0] == $past(eventFlags_r)
    && (eventFlags_r & $past(eventFlags_r) & ~$past(eventRaw & eventMask_r)) == RST_BYTE)
    else $error("event read did not clear");
  ovf_wrap_a: assert property (cntWrap[1] |=> ovfLatch_r[1])
    else $error("multiframe wrap not latched");
  ovf_hold_a: assert property (ovfLatch_r[7] && !rdOvf && !wrPend_r
    |=> ovfLatch_r[7]) else $error("overflow latch dropped");
  mask_gate_a: assert property (!eventFlags_r[EVT_SIG] && !eventMask_r[EVT_SIG]
    |=> !eventFlags_r[EVT_SIG]) else $error("masked source set flag");
  set_wins_a: assert property (rdOvf && cntWrap[3] |=> ovfLatch_r[3])
    else $error("event lost under read");
endmodule
`default_nettype wire

// >>> hw/tel_pkg.sv
// package: register map, bit layout, timing and carrier types of the T1 event latches
`default_nettype none
package tel_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_EVENT_FLAGS = 8'h1E;
  localparam logic [7:0] IDX_OVF_LATCHES = 8'h1F;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h20;
  localparam logic [7:0] IDX_OVF_MASK = 8'h21;
  localparam logic [7:0] IDX_CONTROL = 8'h22;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  // ----------------------------------------------------------------
  // event word and control bit positions, reset byte
  // ----------------------------------------------------------------
  localparam int EVT_HDLC0 = 7;
  localparam int EVT_LOOP = 4;
  localparam int EVT_ONESEC = 3;
  localparam int EVT_FIVESEC = 2;
  localparam int EVT_BOM = 1;
  localparam int EVT_SIG = 0;
  localparam int CTL_DEBOUNCE = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // counters, message and timing figures
  // ----------------------------------------------------------------
  localparam int NUM_COUNTERS = 8;
  localparam logic [7:0] CNT_ALL_ONES = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] BOM_FLAG = 8'hFE;
  localparam int BOM_WIDTH = 15;
  localparam int BOM_CODE_W = 6;
  localparam int BOM_WINDOW = 10;
  localparam int BOM_NEEDED = 8;
  localparam int SIG_WIDTH = 4;
  localparam int CLK_HZ = 20_000_000;
  localparam int LOOP_HOLD_MS = 48;
  localparam int LOOP_HOLD_CYC = LOOP_HOLD_MS * (CLK_HZ / 1000);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------------
  // carriers of the line-side status and link data inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] hdlcIrq;
    logic loopUpSeen;
    logic loopDownSeen;
    logic oneSecStatus;
    logic fiveSecStatus;
  } tel_line_status_t;
  typedef struct packed {
    logic bomStrobe;
    logic [BOM_WIDTH-1:0] bomWord;
    logic sigStrobe;
    logic [SIG_WIDTH-1:0] sigSample;
  } tel_link_data_t;
endpackage
`default_nettype wire

// >>> dv/test_tel_event_latches.sv
// self-checking testbench for the T1 event flag word and counter overflow latches
`default_nettype none
module test_tel_event_latches import tel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  // short loop hold keeps the run small; expectations derive from it
  localparam int HOLD = 20;
  logic core_clk = 1'b0;
  logic reset_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  tel_line_status_t ls;
  tel_link_data_t ld;
  logic [NUM_COUNTERS-1:0][7:0] pc;
  int errorCnt = 0;
  int totalChecks = 0;
  always #25 core_clk = ~core_clk;
  // hready is the single slave's own hreadyout
  tel_event_latches #(.LoopHoldCycles(HOLD)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lineStatus(ls),
    .linkData(ld), .perfCount(pc), .irq(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // bounded wait: a slave that never answers ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      errorCnt++;
      wrapUp();
    end
  endtask
  // one single transfer; evt pulses the hdlc inputs during the address phase
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [2:0] evt);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    ls.hdlcIrq <= evt;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    ls.hdlcIrq <= 3'h0;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 3'h0);
    chk(rd, {24'h0, exp});
  endtask
  task automatic bom(input logic [5:0] code, input int n);
    repeat (n) begin
      ld.bomStrobe <= 1'b1;
      ld.bomWord <= {BOM_FLAG, code, 1'b0};
      tick(1);
      ld.bomStrobe <= 1'b0;
      tick(1);
    end
  endtask
  task automatic sig(input logic [3:0] s);
    ld.sigStrobe <= 1'b1;
    ld.sigSample <= s;
    tick(1);
    ld.sigStrobe <= 1'b0;
    tick(1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tReset();
    rdChk(IDX_EVENT_FLAGS, RST_BYTE);
    rdChk(IDX_OVF_LATCHES, RST_BYTE);
    rdChk(8'h30, 8'h00);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask
  task automatic tHdlc();
    ls.hdlcIrq <= 3'h7;
    tick(1);
    ls.hdlcIrq <= 3'h0;
    tick(2);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    bus(1'b1, IDX_EVENT_MASK, 8'hFF, 3'h0);
    for (int i = 0; i < 3; i++) begin
      ls.hdlcIrq <= 3'h1 << i;
      tick(1);
      ls.hdlcIrq <= 3'h0;
      tick(2);
      chk({31'h0, irq}, 32'h1);
      rdChk(IDX_EVENT_FLAGS, 8'h20 << i);
      rdChk(IDX_EVENT_FLAGS, 8'h00);
    end
    $display("test hdlc done");
  endtask
  task automatic tLoop();
    ls.loopUpSeen <= 1'b1;
    tick(HOLD - 1);
    ls.loopUpSeen <= 1'b0;
    tick(2);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    ls.loopDownSeen <= 1'b1;
    tick(HOLD);
    rdChk(IDX_EVENT_FLAGS, 8'h10);
    tick(HOLD);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    ls.loopDownSeen <= 1'b0;
    $display("test loop done");
  endtask
  task automatic tSec();
    ls.oneSecStatus <= 1'b1;
    tick(2);
    rdChk(IDX_EVENT_FLAGS, 8'h08);
    ls.fiveSecStatus <= 1'b1;
    tick(2);
    rdChk(IDX_EVENT_FLAGS, 8'h04);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    ls.oneSecStatus <= 1'b0;
    ls.fiveSecStatus <= 1'b0;
    tick(2);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    $display("test seconds done");
  endtask
  task automatic tBom();
    bom(6'h05, BOM_NEEDED - 1);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    bom(6'h05, 1);
    rdChk(IDX_EVENT_FLAGS, 8'h02);
    bom(6'h05, 3);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    // interleaved foreign code: the new one needs 8 of the last 10
    bom(6'h09, 2);
    bom(6'h11, 2);
    bom(6'h09, 5);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    bom(6'h09, 1);
    rdChk(IDX_EVENT_FLAGS, 8'h02);
    // words with a broken frame pattern take message positions but never count as matches
    repeat (BOM_WINDOW) begin
      ld.bomStrobe <= 1'b1;
      ld.bomWord <= {BOM_FLAG, 6'h2A, 1'b1};
      tick(1);
      ld.bomStrobe <= 1'b0;
      tick(1);
    end
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    $display("test message done");
  endtask
  task automatic tSig();
    sig(4'h3);
    rdChk(IDX_EVENT_FLAGS, 8'h01);
    sig(4'h3);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    bus(1'b1, IDX_CONTROL, 8'h01, 3'h0);
    sig(4'h5);
    rdChk(IDX_EVENT_FLAGS, 8'h00);
    sig(4'h5);
    rdChk(IDX_EVENT_FLAGS, 8'h01);
    $display("test signalling done");
  endtask
  task automatic tOvf();
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      pc[i] <= CNT_ALL_ONES;
      tick(1);
      pc[i] <= CNT_ZERO;
      tick(4);
      chk({31'h0, irq}, 32'h0);
      rdChk(IDX_OVF_LATCHES, 8'h01 << i);
    end
    rdChk(IDX_OVF_LATCHES, 8'h00);
    pc[7] <= 8'hFE;
    tick(1);
    pc[7] <= CNT_ZERO;
    tick(2);
    rdChk(IDX_OVF_LATCHES, 8'h00);
    // wrap lands in the very cycle of the clearing read
    bus(1'b1, IDX_OVF_MASK, 8'h08, 3'h0);
    pc[3] <= CNT_ALL_ONES;
    tick(1);
    pc[3] <= CNT_ZERO;
    bus(1'b0, IDX_OVF_LATCHES, 8'h00, 3'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdChk(IDX_OVF_LATCHES, 8'h08);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");
  endtask
  task automatic tRace();
    bus(1'b0, IDX_EVENT_FLAGS, 8'h00, 3'h4);
    chk(rd, 32'h0);
    rdChk(IDX_EVENT_FLAGS, 8'h80);
    ls.hdlcIrq <= 3'h6;
    tick(1);
    bus(1'b1, IDX_EVENT_FLAGS, 8'h80, 3'h0);
    rdChk(IDX_EVENT_FLAGS, 8'h40);
    $display("test read race done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    ls = '0;
    ld = '0;
    pc = '0;
    tick(6);
    reset_n <= 1'b1;
    tick(2);
    tReset();
    tHdlc();
    tLoop();
    tSec();
    tBom();
    tSig();
    tOvf();
    tRace();
    wrapUp();
  end
endmodule
`default_nettype wire
